// >>> logic/pm_status_pkg.sv
// constants for the upper power-management event status byte
package pm_status_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_STATUS_UPPER = 4'h1;
  localparam logic [3:0] OFF_CONFIG = 4'h4;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h5;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h6;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h7;
  localparam logic [3:0] OFF_GPE_TWO = 4'h8;
  localparam logic [3:0] OFF_GPE_THREE = 4'h9;
  // status upper fields
  localparam int BIT_WAKE = 7;
  localparam int BIT_IGNORED = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_POWER = 0;
  // power config fields
  localparam int CFG_ALARM_PERMIT = 0;
  localparam int CFG_SLEEP_PERMIT = 1;
  localparam int CFG_POWER_PERMIT = 2;
  localparam int CFG_LEGACY = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // general-purpose status field positions
  localparam int GPE_SLEEP_BIT = 0;
  localparam int GPE_POWER_BIT = 1;
  localparam int GPE_ALARM_BIT = 0;
  // interrupt status fields, one per flag
  localparam int IRQ_W = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // debounce time
  localparam int DEBOUNCE_US = 16;
  localparam int CLK_MHZ = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
endpackage

// >>> logic/pm_status_upper.sv
// upper power-management event status byte with debounced buttons and interrupt
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - each flag is set while its source is high and stays set until software writes one to it.
// - the wake flag (bit 7) is set only by an enabled event while the system sleeps.
// - writing one to the wake flag in the working state clears it, writing zero does nothing.
// - in a sleep state with an enabled event still active, writing one leaves the wake flag set.
// - writes to bit 3 are discarded and its read value is not to be relied on (reads zero here).
// - the alarm flag (bit 2) is set when the clock alarm becomes active.
// - writing one to the alarm flag clears it and the alarm bit of general-purpose status three.
// - the alarm flag is held at zero while the alarm event permit bit is zero.
// - the sleep-button flag (bit 1) is set on a debounced sleep-button press.
// - writing one to the sleep-button flag clears it and its bit of general-purpose status two.
// - the sleep-button flag is held at zero while the sleep-button event permit bit is zero.
// - the power-button flag (bit 0) is set on a debounced power-button press.
// - writing one to the power-button flag clears it and its bit of general-purpose status two.
// - the power-button flag is held at zero while the power-button event permit bit is zero.
// - in legacy button mode a press that turns off main power clears the power-button flag.
// - all flags, reserved bits 6 to 4 included, reset to zero.
module pm_status_upper #(
  parameter int DEBOUNCE_CYCLES = pm_status_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic sleep_state,
  input wire logic wake_event_active,
  input wire logic alarm_active,
  input wire logic sleep_button_input,
  input wire logic power_button_input,
  input wire logic main_power_off,
  output logic irq
);
  // the debounce counter is 16 bits wide, so refuse windows it cannot count
  generate
    if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 65535)
    begin : gen_bad_debounce
      $error("debounce count out of range");
    end
  endgenerate

  // reset release through two flops
  // assert is immediate, release waits two edges so every flop leaves reset on the same edge
  logic rst_s1_reg;
  logic rst_sync_b;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_sync_b <= rst_s1_reg;
    end
  end

  // pin inputs: two flops, first one read by nobody else
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_reg;
  assign pin_raw = {main_power_off, power_button_input, sleep_button_input,
                    alarm_active, wake_event_active, sleep_state};
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      pin_s1_reg <= '0;
      pin_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_reg <= pin_s1_reg;
    end
  end
  logic sleeping;
  logic wake_src;
  logic alarm_src;
  logic power_off;
  assign sleeping = pin_reg[0];
  assign wake_src = pin_reg[1];
  assign alarm_src = pin_reg[2];
  assign power_off = pin_reg[5];

  // button debounce: a level counts only after it held stable for the whole window
  logic [1:0] btn_raw;
  wire logic [1:0] btn_db;
  assign btn_raw = pin_reg[4:3];
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_db
      logic [15:0] cnt_reg;
      logic db_reg;
      // each button keeps its own flop so no bit of a shared vector has two writers
      always_ff @(posedge clk_sys or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
        begin
          cnt_reg <= 16'h0000;
          db_reg <= 1'b0;
        end
        else if (btn_raw[g] == db_reg)
          cnt_reg <= 16'h0000;
        else if (cnt_reg == 16'(DEBOUNCE_CYCLES - 1))
        begin
          cnt_reg <= 16'h0000;
          db_reg <= btn_raw[g];
        end
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
      assign btn_db[g] = db_reg;
    end
  endgenerate
  logic sleep_btn;
  logic power_btn;
  logic power_btn_q_reg;
  assign sleep_btn = btn_db[0];
  assign power_btn = btn_db[1];
  // delayed copy marks the press edge for the set check
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      power_btn_q_reg <= 1'b0;
    else
      power_btn_q_reg <= power_btn;
  end

  // decode
  logic wr_status;
  logic wr_cfg;
  logic wr_gpe2;
  logic wr_gpe3;
  assign wr_status = wr_stb && addr == pm_status_pkg::OFF_STATUS_UPPER;
  assign wr_cfg = wr_stb && addr == pm_status_pkg::OFF_CONFIG;
  assign wr_gpe2 = wr_stb && addr == pm_status_pkg::OFF_GPE_TWO;
  assign wr_gpe3 = wr_stb && addr == pm_status_pkg::OFF_GPE_THREE;
  logic wr_irq_clr;
  logic wr_irq_en;
  assign wr_irq_clr = wr_stb && addr == pm_status_pkg::OFF_IRQ_CLEAR;
  assign wr_irq_en = wr_stb && addr == pm_status_pkg::OFF_IRQ_ENABLE;

  // power configuration: event permits and legacy mode
  logic [7:0] power_config_reg;
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      power_config_reg <= pm_status_pkg::CFG_RESET;
    else if (wr_cfg)
      power_config_reg <= wdata;
  end
  logic alarm_event_permit;
  logic sleep_button_event_permit;
  logic power_button_event_permit;
  logic legacy_button_mode;
  assign alarm_event_permit = power_config_reg[pm_status_pkg::CFG_ALARM_PERMIT];
  assign sleep_button_event_permit = power_config_reg[pm_status_pkg::CFG_SLEEP_PERMIT];
  assign power_button_event_permit = power_config_reg[pm_status_pkg::CFG_POWER_PERMIT];
  assign legacy_button_mode = power_config_reg[pm_status_pkg::CFG_LEGACY];

  // clear strobes: one from status write, alarm and button ones also honoured from gpe writes (mirrored)
  logic clr_wake;
  logic clr_alarm;
  logic clr_sleep;
  logic clr_power;
  logic legacy_off;
  assign clr_wake = wr_status && wdata[pm_status_pkg::BIT_WAKE] && !(sleeping && wake_src);
  assign clr_alarm = (wr_status && wdata[pm_status_pkg::BIT_ALARM])
                     || (wr_gpe3 && wdata[pm_status_pkg::GPE_ALARM_BIT]);
  assign clr_sleep = (wr_status && wdata[pm_status_pkg::BIT_SLEEP])
                     || (wr_gpe2 && wdata[pm_status_pkg::GPE_SLEEP_BIT]);
  assign clr_power = (wr_status && wdata[pm_status_pkg::BIT_POWER])
                     || (wr_gpe2 && wdata[pm_status_pkg::GPE_POWER_BIT]);
  assign legacy_off = legacy_button_mode && power_btn && power_off;

  // sticky flags; set wins over a software clear
  logic wake_event_flag;
  logic alarm_event_flag;
  logic sleep_button_flag;
  logic power_button_flag;
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      wake_event_flag <= 1'b0;
    else if (sleeping && wake_src)
      wake_event_flag <= 1'b1;
    else if (clr_wake)
      wake_event_flag <= 1'b0;
  end
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      alarm_event_flag <= 1'b0;
    else if (!alarm_event_permit)
      alarm_event_flag <= 1'b0;
    else if (alarm_src)
      alarm_event_flag <= 1'b1;
    else if (clr_alarm)
      alarm_event_flag <= 1'b0;
  end
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      sleep_button_flag <= 1'b0;
    else if (!sleep_button_event_permit)
      sleep_button_flag <= 1'b0;
    else if (sleep_btn)
      sleep_button_flag <= 1'b1;
    else if (clr_sleep)
      sleep_button_flag <= 1'b0;
  end
  // legacy shutoff beats a held button, otherwise the flag would never drop
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      power_button_flag <= 1'b0;
    else if (!power_button_event_permit)
      power_button_flag <= 1'b0;
    else if (legacy_off)
      power_button_flag <= 1'b0;
    else if (power_btn)
      power_button_flag <= 1'b1;
    else if (clr_power)
      power_button_flag <= 1'b0;
  end

  // general-purpose mirror bits, cleared by the same writes as the main flags; a withdrawn permit leaves them set
  // legacy shutoff leaves the mirror alone: that clear is only defined for the status byte
  logic gpe_alarm_flag;
  logic gpe_sleep_button_flag;
  logic gpe_power_button_flag;
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      gpe_alarm_flag <= 1'b0;
      gpe_sleep_button_flag <= 1'b0;
      gpe_power_button_flag <= 1'b0;
    end
    else
    begin
      if (alarm_src && alarm_event_permit)
        gpe_alarm_flag <= 1'b1;
      else if (clr_alarm)
        gpe_alarm_flag <= 1'b0;
      if (sleep_btn && sleep_button_event_permit)
        gpe_sleep_button_flag <= 1'b1;
      else if (clr_sleep)
        gpe_sleep_button_flag <= 1'b0;
      if (power_btn && power_button_event_permit)
        gpe_power_button_flag <= 1'b1;
      else if (clr_power)
        gpe_power_button_flag <= 1'b0;
    end
  end

  // interrupt block: sticky on flag rise, write-one clear, enable mask
  logic [3:0] flags;
  logic [3:0] flags_q_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_enable_reg;
  assign flags = {wake_event_flag, alarm_event_flag, sleep_button_flag, power_button_flag};
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      flags_q_reg <= 4'h0;
      irq_status_reg <= 4'h0;
      irq_enable_reg <= 4'h0;
    end
    else
    begin
      flags_q_reg <= flags;
      // set wins over clear
      irq_status_reg <= (irq_status_reg & ~(wr_irq_clr ? wdata[3:0] : 4'h0))
                        | (flags & ~flags_q_reg);
      if (wr_irq_en)
        irq_enable_reg <= wdata[3:0];
    end
  end
  assign irq = |(irq_status_reg & irq_enable_reg);

  // read mux; bit 3 and reserved bits read zero
  // rdata falls back to zero after one cycle so stale data never looks like a fresh answer
  logic [7:0] status_view;
  assign status_view = {wake_event_flag, 3'h0, 1'b0, alarm_event_flag, sleep_button_flag,
                        power_button_flag};
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      rdata <= 8'h00;
    else if (!rd_stb)
      rdata <= 8'h00;
    else
    begin
      case (addr)
        pm_status_pkg::OFF_STATUS_UPPER: rdata <= status_view;
        pm_status_pkg::OFF_CONFIG: rdata <= power_config_reg;
        pm_status_pkg::OFF_IRQ_STATUS: rdata <= {4'h0, irq_status_reg};
        pm_status_pkg::OFF_IRQ_ENABLE: rdata <= {4'h0, irq_enable_reg};
        pm_status_pkg::OFF_GPE_TWO: rdata <= {6'h00, gpe_power_button_flag, gpe_sleep_button_flag};
        pm_status_pkg::OFF_GPE_THREE: rdata <= {7'h00, gpe_alarm_flag};
        default: rdata <= 8'h00;
      endcase
    end
  end

  // assertions
  // wake flag: set only asleep, cleared by a one while working, held while an event stays
  wake_only_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    $rose(wake_event_flag) |-> $past(sleeping && wake_src))
    else $error("wake flag set outside sleep");
  wake_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (wr_status && wdata[pm_status_pkg::BIT_WAKE] && !sleeping && !wake_src) |=> !wake_event_flag)
    else $error("wake clear failed");
  wake_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (sleeping && wake_src) |=> wake_event_flag)
    else $error("wake flag not held");
  wake_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (wake_event_flag && !(wr_status && wdata[pm_status_pkg::BIT_WAKE])) |=> wake_event_flag)
    else $error("wake flag lost without a write of one");
  // permits: a withdrawn permit pins its flag low whatever the source does
  alarm_permit_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !alarm_event_permit |=> !alarm_event_flag)
    else $error("alarm flag not forced low");
  sleep_permit_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !sleep_button_event_permit |=> !sleep_button_flag)
    else $error("sleep flag not forced low");
  power_permit_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !power_button_event_permit |=> !power_button_flag)
    else $error("power flag not forced low");
  // set paths: a live source with its permit shows one edge later, the power flag only outside legacy shutoff
  alarm_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (alarm_src && alarm_event_permit) |=> (alarm_event_flag && gpe_alarm_flag))
    else $error("alarm flag not set");
  sleep_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (sleep_btn && sleep_button_event_permit) |=> (sleep_button_flag && gpe_sleep_button_flag))
    else $error("sleep flag not set");
  power_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (power_btn && !power_btn_q_reg && power_button_event_permit && !legacy_off) |=> power_button_flag)
    else $error("power flag not set");
  // clears: one write drops the flag and its general-purpose mirror together, legacy shutoff only the power flag; alarm flag holds without a clear
  alarm_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (clr_alarm && !alarm_src) |=> (!alarm_event_flag && !gpe_alarm_flag))
    else $error("alarm clear");
  sleep_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (clr_sleep && !sleep_btn) |=> (!sleep_button_flag && !gpe_sleep_button_flag))
    else $error("sleep clear");
  power_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (clr_power && !power_btn) |=> (!power_button_flag && !gpe_power_button_flag))
    else $error("power clear");
  sticky_alarm_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (alarm_event_flag && alarm_event_permit && !clr_alarm) |=> alarm_event_flag)
    else $error("alarm lost");
  legacy_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    legacy_off |=> !power_button_flag)
    else $error("legacy clear failed");
  // read side and interrupt level
  bit3_read_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (rd_stb && addr == pm_status_pkg::OFF_STATUS_UPPER) |=> rdata[6:3] == 4'h0)
    else $error("reserved bits");
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !rd_stb |=> (rdata == 8'h00))
    else $error("read data outside its cycle");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    ($rose(sleep_button_flag) ##0 (irq_enable_reg[1] && !wr_irq_en)) |=> irq)
    else $error("irq missing");
  wake_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) $rose(wake_event_flag));
  sleep_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) $rose(sleep_button_flag));
  power_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) $rose(power_button_flag));
  legacy_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) legacy_off && power_button_flag);
  irq_cov: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) $rose(irq));
endmodule

// >>> tb/pm_status_upper_tb.sv
// self-checking bench for the upper power-management event status byte
`timescale 1ns/1ps
module pm_status_upper_tb;
  localparam int DEB = 4;
  // two sync flops, debounce window and set stage, plus margin so slow paths still land
  localparam int SETTLE = DEB + 6;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic sleep_state = 1'b0;
  logic wake_event_active = 1'b0;
  logic alarm_active = 1'b0;
  logic [1:0] btn = 2'b00; // bit 0 sleep button, bit 1 power button
  logic main_power_off = 1'b0;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;

  // short debounce keeps the run brief
  pm_status_upper #(.DEBOUNCE_CYCLES(DEB)) u_dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .sleep_state(sleep_state),
    .wake_event_active(wake_event_active),
    .alarm_active(alarm_active),
    .sleep_button_input(btn[0]),
    .power_button_input(btn[1]),
    .main_power_off(main_power_off),
    .irq(irq)
  );

  // 100 ns period
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look mid-cycle there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    check(rdata, exp);
    @(posedge clk_sys); // hand back on a rising edge so pins change there
  endtask

  // irq is a level of registers, give the last write time to land
  task automatic irq_is(input logic e);
    idle(2);
    @(negedge clk_sys);
    check({7'h00, irq}, {7'h00, e});
    @(posedge clk_sys);
  endtask

  // press long enough to pass the debounce, then release for as long
  task automatic press(input int b);
    @(posedge clk_sys);
    btn[b] <= 1'b1;
    idle(SETTLE);
    btn[b] <= 1'b0;
    idle(SETTLE);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard: a run that outlives this counts as a mismatch
  initial
  begin
    idle(20000);
    n_errors++;
    $display("ERROR t=%0t run did not complete", $time);
    tally_and_finish;
  end

  initial
  begin
    idle(4);
    rst_b <= 1'b1;
    idle(3);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_CONFIG, pm_status_pkg::CFG_RESET);
    // permits clear after reset: the alarm and both buttons must be ignored
    alarm_active <= 1'b1;
    press(0);
    press(1);
    alarm_active <= 1'b0;
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    // alarm: sticky flag, mirror bit and interrupt
    wr(pm_status_pkg::OFF_CONFIG, 8'h07);
    wr(pm_status_pkg::OFF_IRQ_ENABLE, 8'h04);
    alarm_active <= 1'b1;
    idle(SETTLE);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h04);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h04);
    irq_is(1'b1);
    rd(pm_status_pkg::OFF_IRQ_STATUS, 8'h04);
    alarm_active <= 1'b0;
    idle(4);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h04);
    rd(pm_status_pkg::OFF_GPE_THREE, 8'h01);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h04);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_GPE_THREE, 8'h00);
    // interrupt status is sticky on its own: mask, unmask, clear
    wr(pm_status_pkg::OFF_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    wr(pm_status_pkg::OFF_IRQ_ENABLE, 8'h04);
    irq_is(1'b1);
    wr(pm_status_pkg::OFF_IRQ_CLEAR, 8'h04);
    irq_is(1'b0);
    rd(pm_status_pkg::OFF_IRQ_STATUS, 8'h00);
    // withdrawing the permit forces a set alarm flag low
    alarm_active <= 1'b1;
    idle(SETTLE);
    wr(pm_status_pkg::OFF_CONFIG, 8'h06);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    alarm_active <= 1'b0;
    idle(4);
    wr(pm_status_pkg::OFF_CONFIG, 8'h07);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h04);
    // interrupt now follows only the sleep button
    wr(pm_status_pkg::OFF_IRQ_CLEAR, 8'h0f);
    wr(pm_status_pkg::OFF_IRQ_ENABLE, 8'h02);
    // sleep button: a glitch shorter than the debounce is filtered
    @(posedge clk_sys);
    btn[0] <= 1'b1;
    idle(DEB - 2);
    btn[0] <= 1'b0;
    idle(SETTLE);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    irq_is(1'b0);
    press(0);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h02);
    irq_is(1'b1);
    rd(pm_status_pkg::OFF_GPE_TWO, 8'h01);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h02);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_GPE_TWO, 8'h00);
    // power button, cleared through its general-purpose mirror
    press(1);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h01);
    rd(pm_status_pkg::OFF_GPE_TWO, 8'h02);
    wr(pm_status_pkg::OFF_GPE_TWO, 8'h02);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_GPE_TWO, 8'h00);
    // legacy mode: a press that drops main power clears the flag
    press(1);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h01);
    wr(pm_status_pkg::OFF_CONFIG, 8'h0f);
    main_power_off <= 1'b1;
    press(1);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    main_power_off <= 1'b0;
    wr(pm_status_pkg::OFF_CONFIG, 8'h07);
    // wake: ignored while working, held while sleeping with an event active
    wake_event_active <= 1'b1;
    idle(SETTLE);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    sleep_state <= 1'b1;
    idle(SETTLE);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h80);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h80);
    wake_event_active <= 1'b0;
    sleep_state <= 1'b0;
    idle(SETTLE);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h80);
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'h80);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    // ignored and reserved bits take no write, unmapped place reads zero
    wr(pm_status_pkg::OFF_STATUS_UPPER, 8'hff);
    rd(pm_status_pkg::OFF_STATUS_UPPER, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    tally_and_finish;
  end
endmodule
